// ==== verilog/rglc_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "rglc_consts.vh"
module rglc_top #(
	parameter CH = 8,
	parameter POR_CYC = `RGLC_POR_FILT_CYC,
	parameter GLITCH_CYC = `RGLC_GLITCH_CYC
) (
	// Clock and reset
	input wire clk_in,
	input wire rst_n_in,
	// Analog monitor flags, high while the fault is present
	input wire vdd_filtered_reset_level_in,
	input wire vdd_fast_reset_level_in,
	input wire ref_resistor_upper_limit_in,
	input wire ref_resistor_lower_limit_in,
	input wire logic_ground_lost_in,
	// External reset pin
	input wire external_reset_n_in,
	// Deployment in progress from the firing logic
	input wire deploy_active_in,
	// Per-channel driver requests and ground monitors
	input wire [CH-1:0] high_side_req_in,
	input wire [CH-1:0] low_side_req_in,
	input wire [CH-1:0] channel_power_ground_lost_in,
	// Reset to the rest of the device, active low
	output reg core_rst_n_out,
	// Global output enable
	output reg outputs_enable_out,
	// Driver gates
	output reg [CH-1:0] squib_high_side_driver_out,
	output reg [CH-1:0] squib_low_side_driver_out,
	// Low side diagnostic fault per channel
	output reg [CH-1:0] low_side_diag_fault_out
);
	wire por_filt;
	wire ext_filt;
	wire supply_rst;
	wire other_rst;
	wire ext_rst;
	wire any_rst;
	reg sync1_r;
	reg sync2_r;
	reg dep_r;

	rglc_filter #(.LEN(POR_CYC), .W(`RGLC_CNT_W)) u_por_filt (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.level_in(vdd_filtered_reset_level_in),
		.hold_out(por_filt)
	);
	rglc_filter #(.LEN(GLITCH_CYC), .W(`RGLC_CNT_W)) u_ext_filt (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.level_in(~external_reset_n_in),
		.hold_out(ext_filt)
	);

	// Supply faults bypass the deployment guard; the fast level has no filter.
	assign supply_rst = por_filt | vdd_fast_reset_level_in;
	assign other_rst = ref_resistor_upper_limit_in | ref_resistor_lower_limit_in |
		logic_ground_lost_in;
	// Deployment state is also sampled so that the guard holds one cycle after deployment ends.
	assign ext_rst = ext_filt & ~(deploy_active_in | dep_r);
	assign any_rst = supply_rst | other_rst | ext_rst;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			dep_r <= `RGLC_DEP_RST;
		else
			dep_r <= deploy_active_in & ~supply_rst;
	end

	// Synchronous assert on the next clock edge, two-stage synchronous release of the combined reset.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else if (any_rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= 1'b1;
			sync2_r <= sync1_r;
		end
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			core_rst_n_out <= 1'b0;
			outputs_enable_out <= `RGLC_EN_RST;
			squib_high_side_driver_out <= {CH{1'b0}};
			squib_low_side_driver_out <= {CH{1'b0}};
			low_side_diag_fault_out <= {CH{1'b0}};
		end else if (any_rst) begin
			core_rst_n_out <= 1'b0;
			outputs_enable_out <= 1'b0;
			squib_high_side_driver_out <= {CH{1'b0}};
			squib_low_side_driver_out <= {CH{1'b0}};
			low_side_diag_fault_out <= {CH{1'b0}};
		end else begin
			core_rst_n_out <= sync2_r;
			outputs_enable_out <= sync2_r;
			squib_high_side_driver_out <= high_side_req_in & {CH{sync2_r}};
			squib_low_side_driver_out <= low_side_req_in & ~channel_power_ground_lost_in &
				{CH{sync2_r}};
			// The fault shows only while the low side is requested on the channel, whose low side driver is then held off.
			low_side_diag_fault_out <= low_side_req_in & channel_power_ground_lost_in &
				{CH{sync2_r}};
		end
	end
endmodule
`default_nettype wire

// ==== verilog/rglc_consts.vh ====
`ifndef RGLC_CONSTS_VH
`define RGLC_CONSTS_VH
// Clock rate in kHz.
`define RGLC_CLK_KHZ 25000
// Supply reset filter time in microseconds.
`define RGLC_POR_FILT_US 10
// Reset deglitch time in microseconds.
`define RGLC_GLITCH_US 2
// Filtered low supply must persist this many cycles (least time, rounded up).
`define RGLC_POR_FILT_CYC ((`RGLC_POR_FILT_US * `RGLC_CLK_KHZ + 999) / 1000)
// External reset shorter than this many cycles is ignored (rounded up).
`define RGLC_GLITCH_CYC ((`RGLC_GLITCH_US * `RGLC_CLK_KHZ + 999) / 1000)
// Width of the filter counters.
`define RGLC_CNT_W 16
// Reset value of the output enable register.
`define RGLC_EN_RST 1'b0
// Reset value of the deploy flag.
`define RGLC_DEP_RST 1'b0
`endif

// ==== verilog/rglc_filter.v ====
`timescale 1ns/1ps
`default_nettype none
// Passes a level high only after it has stayed high for LEN consecutive cycles.
module rglc_filter #(
	parameter LEN = 1,
	parameter W = 16
) (
	// Clock and reset
	input wire clk_in,
	input wire rst_n_in,
	// Level to qualify
	input wire level_in,
	// Qualified level
	output reg hold_out
);
	reg [W-1:0] cnt_r;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= {W{1'b0}};
			hold_out <= 1'b0;
		end else if (!level_in) begin
			cnt_r <= {W{1'b0}};
			hold_out <= 1'b0;
		end else if (cnt_r >= LEN[W-1:0] - 1'b1) begin
			hold_out <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== verif/rglc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module rglc_chk #(parameter CH = 8) (
	input wire logic clk_in, rst_n_in, vdd_filtered_reset_level_in, vdd_fast_reset_level_in,
	input wire logic logic_ground_lost_in, core_rst_n_out, outputs_enable_out,
	input wire logic ref_resistor_upper_limit_in, ref_resistor_lower_limit_in,
	input wire logic [CH-1:0] channel_power_ground_lost_in, squib_low_side_driver_out,
	input wire logic [CH-1:0] low_side_diag_fault_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_held; !core_rst_n_out [*3]; endsequence
	property p_fast; vdd_fast_reset_level_in |=> s_held; endproperty
	a_fast: assert property (p_fast) else $error("fast supply");
	// Five samples suit the filter length of four set by the bench.
	property p_filt; vdd_filtered_reset_level_in [*5] |=> !core_rst_n_out; endproperty
	a_filt: assert property (p_filt) else $error("slow supply");
	property p_gnd; logic_ground_lost_in |=> !outputs_enable_out; endproperty
	a_gnd: assert property (p_gnd) else $error("logic ground");
	property p_ref; (ref_resistor_upper_limit_in | ref_resistor_lower_limit_in) |=>
		!outputs_enable_out; endproperty
	a_ref: assert property (p_ref) else $error("reference resistor");
	property p_diag; (low_side_diag_fault_out & ~$past(channel_power_ground_lost_in)) == '0;
	endproperty
	a_diag: assert property (p_diag) else $error("low side diagnostic");
	property p_low; (squib_low_side_driver_out & $past(channel_power_ground_lost_in)) == '0;
	endproperty
	a_low: assert property (p_low) else $error("low side");
endmodule
bind rglc_top rglc_chk #(.CH(CH)) rglc_chk_inst (.*);
`default_nettype wire

// ==== verif/rglc_mcu.sv ====
`timescale 1ns/1ps
`default_nettype none
module rglc_mcu (input wire logic clk_in, output logic external_reset_n_out = 1'b1);
	task low(input int n);
		@(posedge clk_in) external_reset_n_out <= 1'b0;
		repeat (n) @(posedge clk_in);
		external_reset_n_out <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_in = 1'b0, rst_n_in = 1'b0, deploy_active_in = 1'b0;
	logic [4:0] src = 5'h00;
	logic [7:0] low_side_req_in = 8'h00, channel_power_ground_lost_in = 8'h00;
	wire logic external_reset_n_in, core_rst_n_out, outputs_enable_out;
	wire logic [7:0] squib_high_side_driver_out, squib_low_side_driver_out, low_side_diag_fault_out;
	int errors = 0, checked = 0;
	initial forever #20 clk_in = ~clk_in;
	rglc_top #(.POR_CYC(4), .GLITCH_CYC(3)) rglc_top_inst (.*, .high_side_req_in(low_side_req_in),
		.vdd_filtered_reset_level_in(src[0]), .vdd_fast_reset_level_in(src[1]),
		.ref_resistor_upper_limit_in(src[2]), .ref_resistor_lower_limit_in(src[3]),
		.logic_ground_lost_in(src[4]));
	rglc_mcu rglc_mcu_inst (.clk_in, .external_reset_n_out(external_reset_n_in));
	task chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) errors++;
		if (s !== e) $display("BAD %0t got %h want %h", $time, s, e);
	endtask
	task results(input int late);
		errors += late;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// A zero mask pulses the reset pin; the last wait covers the three-edge release.
	task hit(input logic [4:0] m, input int n, input logic e);
		if (m == 5'h00) rglc_mcu_inst.low(n);
		else src <= m;
		if (m != 5'h00) repeat (n) @(posedge clk_in);
		src <= 5'h00;
		@(posedge clk_in);
		@(negedge clk_in) chk(8'(outputs_enable_out), 8'(e));
		repeat (4) @(posedge clk_in);
	endtask
	task t_src;
		deploy_active_in <= 1'b1;
		hit(5'h02, 1, 1'b0);
		deploy_active_in <= 1'b0;
		hit(5'h01, 3, 1'b1);
		hit(5'h01, 5, 1'b0);
		hit(5'h0c, 1, 1'b0);
		hit(5'h10, 1, 1'b0);
		hit(5'h00, 2, 1'b1);
		hit(5'h00, 5, 1'b0);
		$display("sources done");
	endtask
	task t_dep;
		low_side_req_in <= 8'hff;
		channel_power_ground_lost_in <= 8'h81;
		deploy_active_in <= 1'b1;
		fork
			rglc_mcu_inst.low(12);
		join_none
		repeat (6) @(negedge clk_in);
		chk(8'(outputs_enable_out), 8'h01);
		chk(squib_low_side_driver_out, 8'h7e);
		chk(squib_high_side_driver_out, 8'hff);
		chk(low_side_diag_fault_out, 8'h81);
		@(posedge clk_in) deploy_active_in <= 1'b0;
		repeat (8) @(negedge clk_in);
		chk(8'(outputs_enable_out), 8'h00);
		$display("deploy done");
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(negedge clk_in);
		chk(8'(core_rst_n_out), 8'h00);
		repeat (2) @(negedge clk_in);
		chk(8'(core_rst_n_out), 8'h01);
		@(posedge clk_in);
		t_src;
		t_dep;
		results(0);
	end
	initial #40000 results(1);
endmodule
`default_nettype wire
